// ---- src/ldc_defs.svh ----
/*
 * Constants for the LED driver configuration and scan-limit block:
 * register addresses, configuration bit positions, reset values, timing.
 * Assumes a 200 MHz reference clock standing in for the display oscillator.
 */
`ifndef LDC_DEFS_SVH
`define LDC_DEFS_SVH

// ==========================================================
// Register addresses
`define LDC_ADDR_SCAN      8'h03
`define LDC_ADDR_CFG       8'h04

// ==========================================================
// Configuration bit positions
`define LDC_CFG_RUN        0
`define LDC_CFG_SPARE      1
`define LDC_CFG_FAST       2
`define LDC_CFG_BLINK      3
`define LDC_CFG_SYNC       4
`define LDC_CFG_CLEAR      5
`define LDC_CFG_INDIV      6
`define LDC_CFG_PHASE      7
`define LDC_SCAN_MSB       2

// ==========================================================
// Reset values and bus address
`define LDC_CFG_RST        7'h00
`define LDC_SCAN_RST       3'h7
`define LDC_DEV_ADDR       7'h60

// ==========================================================
// Timing
`define LDC_CLK_KHZ        200000
`define LDC_CLK_PERIOD_NS  5
`define LDC_SLOW_HALF_MS   1000
`define LDC_FAST_HALF_MS   500
`define LDC_SLOW_HALF_CYC  (`LDC_SLOW_HALF_MS * `LDC_CLK_KHZ)
`define LDC_FAST_HALF_CYC  (`LDC_FAST_HALF_MS * `LDC_CLK_KHZ)
`define LDC_DIGIT_NS       1000
`define LDC_DIGIT_CYC      (`LDC_DIGIT_NS / `LDC_CLK_PERIOD_NS)

`endif

// ---- src/ldc_pkg.sv ----
/*
 * Types for the LED driver configuration block.
 * Assumes ldc_defs.svh supplies all numeric constants.
 */
package ldc_pkg;

   // ==========================================================
   // Stored configuration, bit 0 lowest
   typedef struct packed {
      logic indiv;
      logic clear;
      logic sync;
      logic blink_en;
      logic fast;
      logic spare;
      logic run;
   } ldc_cfg_t;

   // ==========================================================
   // Register write carrier from the serial engine
   typedef struct packed {
      logic       wr;
      logic [7:0] addr;
      logic [7:0] data;
   } ldc_wr_t;

   // ==========================================================
   // Serial engine states
   typedef enum logic [8:0] {
      I2C_IDLE  = 9'h001,
      I2C_ADDR  = 9'h002,
      I2C_ACK_A = 9'h004,
      I2C_PTR   = 9'h008,
      I2C_ACK_P = 9'h010,
      I2C_WDATA = 9'h020,
      I2C_ACK_W = 9'h040,
      I2C_RDATA = 9'h080,
      I2C_RACK  = 9'h100
   } ldc_i2c_st_t;

   typedef struct packed {
      logic [1:0]  scl_s;
      logic [1:0]  sda_s;
      logic        scl_p;
      logic        sda_p;
      ldc_i2c_st_t st;
      logic [3:0]  cnt;
      logic [7:0]  sh;
      logic [7:0]  ptr;
      logic        wr;
   } ldc_i2c_reg_t;

   typedef struct packed {
      logic [27:0] cnt;
      logic        phase;
   } ldc_blink_reg_t;

   typedef struct packed {
      ldc_cfg_t   cfg;
      logic [2:0] lim;
      logic [2:0] digit;
      logic [7:0] scan_cnt;
      logic [7:0] seg;
      logic       clr;
   } ldc_top_reg_t;

endpackage

// ---- src/ldc_i2c_slave.sv ----
/*
 * Two-wire serial slave: address byte, register pointer, write bytes with
 * auto-increment, and reads from the pointer onward.
 * Assumes SCL and SDA arrive asynchronously and are far slower than ref_clk.
 */
`timescale 1ns/100ps
`include "ldc_defs.svh"

module ldc_i2c_slave (
   input  wire logic            ref_clk,
   input  wire logic            rst,
   input  wire logic            scl_i,
   input  wire logic            sda_i,
   output logic                 sda_o,
   output logic                 sda_oe,
   input  wire logic [7:0]      rd_data,
   output logic [7:0]           rd_addr,
   output ldc_pkg::ldc_wr_t     wr
);

   ldc_pkg::ldc_i2c_reg_t r_q;
   ldc_pkg::ldc_i2c_reg_t r_d;
   logic                  scl;
   logic                  sda;
   logic                  rise;
   logic                  fall;
   logic                  start;
   logic                  stop;

   // ==========================================================
   // Line events from the second synchroniser stage only
   assign scl   = r_q.scl_s[1];
   assign sda   = r_q.sda_s[1];
   assign rise  = scl & ~r_q.scl_p;
   assign fall  = ~scl & r_q.scl_p;
   assign start = scl & r_q.scl_p & r_q.sda_p & ~sda;
   assign stop  = scl & r_q.scl_p & ~r_q.sda_p & sda;

   // Protocol sequencer
   always_comb begin
      r_d       = r_q;
      r_d.scl_s = {r_q.scl_s[0], scl_i};
      r_d.sda_s = {r_q.sda_s[0], sda_i};
      r_d.scl_p = scl;
      r_d.sda_p = sda;
      r_d.wr    = 1'b0;
      if (start) begin
         r_d.st  = ldc_pkg::I2C_ADDR;
         r_d.cnt = 4'h0;
      end else if (stop) begin
         r_d.st = ldc_pkg::I2C_IDLE;
      end else begin
         unique case (r_q.st)
            ldc_pkg::I2C_IDLE: begin
               r_d.cnt = 4'h0;
            end
            ldc_pkg::I2C_ADDR, ldc_pkg::I2C_PTR, ldc_pkg::I2C_WDATA: begin
               if (rise) begin
                  r_d.sh  = {r_q.sh[6:0], sda};
                  r_d.cnt = r_q.cnt + 4'h1;
               end else if (fall && r_q.cnt == 4'h8) begin
                  r_d.cnt = 4'h0;
                  if (r_q.st == ldc_pkg::I2C_ADDR) begin
                     r_d.st = (r_q.sh[7:1] == `LDC_DEV_ADDR) ? ldc_pkg::I2C_ACK_A : ldc_pkg::I2C_IDLE;
                  end else if (r_q.st == ldc_pkg::I2C_PTR) begin
                     r_d.st  = ldc_pkg::I2C_ACK_P;
                     r_d.ptr = r_q.sh;
                  end else begin
                     r_d.st = ldc_pkg::I2C_ACK_W;
                     r_d.wr = 1'b1;                      // Write lands in the acknowledge
                  end
               end
            end
            ldc_pkg::I2C_ACK_A: begin
               if (fall) begin
                  if (r_q.sh[0]) begin
                     r_d.st = ldc_pkg::I2C_RDATA;
                     r_d.sh = rd_data;
                  end else begin
                     r_d.st = ldc_pkg::I2C_PTR;
                  end
               end
            end
            ldc_pkg::I2C_ACK_P, ldc_pkg::I2C_ACK_W: begin
               if (fall) begin
                  r_d.st = ldc_pkg::I2C_WDATA;
                  if (r_q.st == ldc_pkg::I2C_ACK_W) begin
                     r_d.ptr = r_q.ptr + 8'h01;
                  end
               end
            end
            ldc_pkg::I2C_RDATA: begin
               if (fall) begin
                  r_d.sh  = {r_q.sh[6:0], 1'b0};
                  r_d.cnt = r_q.cnt + 4'h1;
                  if (r_q.cnt == 4'h7) begin
                     r_d.st  = ldc_pkg::I2C_RACK;
                     r_d.cnt = 4'h0;
                  end
               end
            end
            ldc_pkg::I2C_RACK: begin
               if (rise) begin
                  if (sda) begin
                     r_d.st = ldc_pkg::I2C_IDLE;         // Master ends the read
                  end else begin
                     r_d.ptr = r_q.ptr + 8'h01;
                  end
               end else if (fall) begin
                  r_d.st = ldc_pkg::I2C_RDATA;
                  r_d.sh = rd_data;
               end
            end
            default: begin
               r_d.st = ldc_pkg::I2C_IDLE;
            end
         endcase
      end
   end

   // State register
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         r_q <= '{scl_s: 2'h3, sda_s: 2'h3, scl_p: 1'b1, sda_p: 1'b1, st: ldc_pkg::I2C_IDLE,
                  cnt: 4'h0, sh: 8'h00, ptr: 8'h00, wr: 1'b0};
      end else begin
         r_q <= r_d;
      end
   end

   // Open-drain drive: acknowledge low or a zero data bit
   assign sda_o   = 1'b0;
   assign sda_oe  = (r_q.st inside {ldc_pkg::I2C_ACK_A, ldc_pkg::I2C_ACK_P, ldc_pkg::I2C_ACK_W})
                    | ((r_q.st == ldc_pkg::I2C_RDATA) & ~r_q.sh[7]);
   assign rd_addr = r_q.ptr;
   assign wr      = '{wr: r_q.wr, addr: r_q.ptr, data: r_q.sh};

endmodule // ldc_i2c_slave

// ---- src/ldc_blink_timer.sv ----
/*
 * Blink half-period timer with slow and fast rates and a restart input.
 * Assumes sync is a one-cycle pulse on ref_clk.
 */
`timescale 1ns/100ps
`include "ldc_defs.svh"

module ldc_blink_timer #(
   parameter int SLOW_HALF_CYC = `LDC_SLOW_HALF_CYC,
   parameter int FAST_HALF_CYC = `LDC_FAST_HALF_CYC
) (
   input  wire logic ref_clk,
   input  wire logic rst,
   input  wire logic fast,
   input  wire logic sync,
   output logic      phase
);

   ldc_pkg::ldc_blink_reg_t r_q;
   ldc_pkg::ldc_blink_reg_t r_d;
   logic [27:0]             half_last;

   // Last count of the selected half period
   assign half_last = fast ? 28'(FAST_HALF_CYC - 1) : 28'(SLOW_HALF_CYC - 1);

   // Count, flip phase at each half, restart on sync
   always_comb begin
      r_d = r_q;
      if (sync) begin
         r_d.cnt   = 28'h0000000;
         r_d.phase = 1'b1;
      end else if (r_q.cnt >= half_last) begin
         r_d.cnt   = 28'h0000000;
         r_d.phase = ~r_q.phase;
      end else begin
         r_d.cnt = r_q.cnt + 28'h0000001;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         r_q <= '{cnt: 28'h0000000, phase: 1'b1};
      end else begin
         r_q <= r_d;
      end
   end

   assign phase = r_q.phase;

   // ==========================================================
   // Checks
   property p_half_len;
      @(posedge ref_clk) disable iff (rst)
      (r_q.phase != $past(r_q.phase)) && !$past(sync) |-> $past(r_q.cnt) >= $past(half_last);
   endproperty
   a_half_len: assert property (p_half_len) else $error("blink phase flipped early");

   property p_sync_restart;
      @(posedge ref_clk) disable iff (rst)
      sync |=> r_q.cnt == 28'h0000000 && r_q.phase;
   endproperty
   a_sync_restart: assert property (p_sync_restart) else $error("blink sync did not restart");

endmodule // ldc_blink_timer

// ---- src/ldc_top.sv ----
/*
 * LED driver configuration and scan-limit control: serial register access,
 * shutdown, blink rate and enable, two-plane segment blink, blink sync,
 * digit clear request, intensity source select, phase readback, digit scan.
 * Assumes the digit RAM outside presents the two plane words of scan_digit
 * and clears itself on digit_clear.
 */
`timescale 1ns/100ps
`include "ldc_defs.svh"

module ldc_top #(
   parameter int SLOW_HALF_CYC = `LDC_SLOW_HALF_CYC,
   parameter int FAST_HALF_CYC = `LDC_FAST_HALF_CYC
) (
   input  wire logic       ref_clk,
   input  wire logic       rst,
   input  wire logic       scl_i,
   input  wire logic       sda_i,
   output logic            sda_o,
   output logic            sda_oe,
   input  wire logic [7:0] first_half_plane,
   input  wire logic [7:0] second_half_plane,
   output logic [2:0]      scan_digit,
   output logic [7:0]      seg_out,
   output logic            display_on,
   output logic            digit_clear,
   output logic            use_digit_intensity,
   output logic            blink_phase
);

   ldc_pkg::ldc_top_reg_t r_q;
   ldc_pkg::ldc_top_reg_t r_d;
   ldc_pkg::ldc_wr_t      wr;
   logic [7:0]            rd_addr;
   logic [7:0]            rd_data;
   logic                  wr_cfg;
   logic                  wr_scan;
   logic                  sync_pulse;
   logic                  scan_step;

   // ==========================================================
   // Segment map for one plane pair
   function automatic logic [7:0] seg_map(input logic [7:0] p0, input logic [7:0] p1,
                                          input logic en, input logic ph);
      logic [7:0] s;
      if (en) begin
         s = (p0 & p1) | (p0 & {8{ph}}) | (p1 & {8{~ph}});
      end else begin
         s = p0;
      end
      return s;
   endfunction

   // ==========================================================
   // Serial register port
   ldc_i2c_slave u_i2c (
      .ref_clk (ref_clk),
      .rst     (rst),
      .scl_i   (scl_i),
      .sda_i   (sda_i),
      .sda_o   (sda_o),
      .sda_oe  (sda_oe),
      .rd_data (rd_data),
      .rd_addr (rd_addr),
      .wr      (wr)
   );

   // Write decode; sync and clear are taken from the write itself, not the store
   assign wr_cfg     = wr.wr && (wr.addr == `LDC_ADDR_CFG);
   assign wr_scan    = wr.wr && (wr.addr == `LDC_ADDR_SCAN);
   assign sync_pulse = wr_cfg && wr.data[`LDC_CFG_SYNC];

   // Read mux; phase is live, unused scan bits read zero
   always_comb begin
      rd_data = 8'h00;
      if (rd_addr == `LDC_ADDR_CFG) begin
         rd_data = {blink_phase, r_q.cfg};
      end else if (rd_addr == `LDC_ADDR_SCAN) begin
         rd_data = {5'h00, r_q.lim};
      end
   end

   // ==========================================================
   // Blink timing
   ldc_blink_timer #(
      .SLOW_HALF_CYC (SLOW_HALF_CYC),
      .FAST_HALF_CYC (FAST_HALF_CYC)
   ) u_blink (
      .ref_clk (ref_clk),
      .rst     (rst),
      .fast    (r_q.cfg.fast),
      .sync    (sync_pulse),
      .phase   (blink_phase)
   );

   // ==========================================================
   // Register store, digit scan and segment drive
   assign scan_step = r_q.cfg.run && (r_q.scan_cnt == 8'(`LDC_DIGIT_CYC - 1));

   always_comb begin
      r_d     = r_q;
      r_d.clr = 1'b0;
      if (wr_cfg) begin
         r_d.cfg = ldc_pkg::ldc_cfg_t'(wr.data[6:0]);         // Bit 1 stored and read back, drives nothing
         r_d.clr = wr.data[`LDC_CFG_CLEAR];
      end
      if (wr_scan) begin
         r_d.lim = wr.data[`LDC_SCAN_MSB:0];
      end
      // Scan holds still in shutdown
      if (r_q.cfg.run) begin
         if (scan_step) begin
            r_d.scan_cnt = 8'h00;
            r_d.digit    = (r_q.digit >= r_q.lim) ? 3'h0 : r_q.digit + 3'h1;
         end else begin
            r_d.scan_cnt = r_q.scan_cnt + 8'h01;
         end
      end
      // Segments dark in shutdown, mapped otherwise
      if (r_q.cfg.run) begin
         r_d.seg = seg_map(first_half_plane, second_half_plane, r_q.cfg.blink_en, blink_phase);
      end else begin
         r_d.seg = 8'h00;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         r_q <= '{cfg: `LDC_CFG_RST, lim: `LDC_SCAN_RST, digit: 3'h0,
                  scan_cnt: 8'h00, seg: 8'h00, clr: 1'b0};
      end else begin
         r_q <= r_d;
      end
   end

   // Outputs
   assign scan_digit          = r_q.digit;
   assign seg_out             = r_q.seg;
   assign display_on          = r_q.cfg.run;
   assign digit_clear         = r_q.clr;
   assign use_digit_intensity = r_q.cfg.indiv;

   // ==========================================================
   // Checks
   property p_shutdown_dark;
      @(posedge ref_clk) disable iff (rst)
      !r_q.cfg.run |=> seg_out == 8'h00;
   endproperty
   a_shutdown_dark: assert property (p_shutdown_dark) else $error("segments lit in shutdown");

   property p_run_bit;
      @(posedge ref_clk) disable iff (rst)
      wr_cfg |=> display_on == $past(wr.data[`LDC_CFG_RUN]);
   endproperty
   a_run_bit: assert property (p_run_bit) else $error("run bit not taken");

   property p_both_planes;
      @(posedge ref_clk) disable iff (rst)
      r_q.cfg.run && r_q.cfg.blink_en
      |=> ((seg_out ^ $past(first_half_plane)) & ~($past(first_half_plane) ^ $past(second_half_plane))) == 8'h00;
   endproperty
   a_both_planes: assert property (p_both_planes) else $error("steady segment wrong");

   property p_first_plane;
      @(posedge ref_clk) disable iff (rst)
      r_q.cfg.run && r_q.cfg.blink_en
      |=> (seg_out & $past(first_half_plane) & ~$past(second_half_plane))
          == ($past(first_half_plane) & ~$past(second_half_plane) & {8{$past(blink_phase)}});
   endproperty
   a_first_plane: assert property (p_first_plane) else $error("first plane segment wrong");

   property p_second_plane;
      @(posedge ref_clk) disable iff (rst)
      r_q.cfg.run && r_q.cfg.blink_en
      |=> (seg_out & ~$past(first_half_plane) & $past(second_half_plane))
          == (~$past(first_half_plane) & $past(second_half_plane) & {8{~$past(blink_phase)}});
   endproperty
   a_second_plane: assert property (p_second_plane) else $error("second plane segment wrong");

   property p_blink_off;
      @(posedge ref_clk) disable iff (rst)
      r_q.cfg.run && !r_q.cfg.blink_en |=> seg_out == $past(first_half_plane);
   endproperty
   a_blink_off: assert property (p_blink_off) else $error("blink off does not follow plane");

   property p_clear_once;
      @(posedge ref_clk) disable iff (rst)
      wr_cfg && wr.data[`LDC_CFG_CLEAR] |=> digit_clear ##1 !digit_clear;
   endproperty
   a_clear_once: assert property (p_clear_once) else $error("clear not a single pulse");

   property p_clear_cause;
      @(posedge ref_clk) disable iff (rst)
      digit_clear |-> $past(wr_cfg) && $past(wr.data[`LDC_CFG_CLEAR]);
   endproperty
   a_clear_cause: assert property (p_clear_cause) else $error("clear without write");

   property p_intensity_sel;
      @(posedge ref_clk) disable iff (rst)
      wr_cfg |=> use_digit_intensity == $past(wr.data[`LDC_CFG_INDIV]);
   endproperty
   a_intensity_sel: assert property (p_intensity_sel) else $error("intensity source wrong");

   property p_scan_wrap;
      @(posedge ref_clk) disable iff (rst)
      scan_step && (scan_digit >= r_q.lim) |=> scan_digit == 3'h0;
   endproperty
   a_scan_wrap: assert property (p_scan_wrap) else $error("scan passed limit");

   property p_scan_hold;
      @(posedge ref_clk) disable iff (rst)
      !r_q.cfg.run |=> $stable(r_q.scan_cnt);
   endproperty
   a_scan_hold: assert property (p_scan_hold) else $error("scan ran in shutdown");

   property p_run_scan;
      @(posedge ref_clk) disable iff (rst)
      r_q.cfg.run && !scan_step |=> r_q.scan_cnt == $past(r_q.scan_cnt) + 8'h01;
   endproperty
   a_run_scan: assert property (p_run_scan) else $error("scan timer stalled");

   property p_digit_steady;
      @(posedge ref_clk) disable iff (rst)
      !scan_step |=> $stable(scan_digit);
   endproperty
   a_digit_steady: assert property (p_digit_steady) else $error("digit moved between steps");

   property p_digit_step;
      @(posedge ref_clk) disable iff (rst)
      scan_step && (scan_digit < r_q.lim) |=> scan_digit == $past(scan_digit) + 3'h1;
   endproperty
   a_digit_step: assert property (p_digit_step) else $error("digit did not advance");

   property p_lim_write;
      @(posedge ref_clk) disable iff (rst)
      wr_scan |=> r_q.lim == $past(wr.data[`LDC_SCAN_MSB:0]);
   endproperty
   a_lim_write: assert property (p_lim_write) else $error("scan limit not taken");

   property p_fast_sel;
      @(posedge ref_clk) disable iff (rst)
      wr_cfg |=> r_q.cfg.fast == $past(wr.data[`LDC_CFG_FAST]);
   endproperty
   a_fast_sel: assert property (p_fast_sel) else $error("blink rate not taken");

   property p_blink_sel;
      @(posedge ref_clk) disable iff (rst)
      wr_cfg |=> r_q.cfg.blink_en == $past(wr.data[`LDC_CFG_BLINK]);
   endproperty
   a_blink_sel: assert property (p_blink_sel) else $error("blink enable not taken");

   property p_clear_quiet;
      @(posedge ref_clk) disable iff (rst)
      wr_cfg && !wr.data[`LDC_CFG_CLEAR] |=> !digit_clear;
   endproperty
   a_clear_quiet: assert property (p_clear_quiet) else $error("clear without its bit");

   property p_clear_stored;
      @(posedge ref_clk) disable iff (rst)
      !wr_cfg |=> !digit_clear;
   endproperty
   a_clear_stored: assert property (p_clear_stored) else $error("clear repeated from store");

   property p_cfg_hold;
      @(posedge ref_clk) disable iff (rst)
      !wr_cfg |=> $stable(display_on) && $stable(use_digit_intensity);
   endproperty
   a_cfg_hold: assert property (p_cfg_hold) else $error("config moved without write");

   property p_sync_phase;
      @(posedge ref_clk) disable iff (rst)
      sync_pulse |=> blink_phase;
   endproperty
   a_sync_phase: assert property (p_sync_phase) else $error("sync left second phase");

   property p_reset_outputs;
      @(posedge ref_clk)
      $fell(rst) |-> !digit_clear && !use_digit_intensity && blink_phase && scan_digit == 3'h0;
   endproperty
   a_reset_outputs: assert property (p_reset_outputs) else $error("bad outputs after reset");

   property p_reset_state;
      @(posedge ref_clk)
      $fell(rst) |-> !display_on && r_q.lim == 3'h7 && !r_q.cfg.fast && !r_q.cfg.blink_en;
   endproperty
   a_reset_state: assert property (p_reset_state) else $error("bad reset state");

endmodule // ldc_top

// ---- dv/ldc_host_model.sv ----
/*
 * Host bus master model: start, stop, byte transfers, register write/read.
 * Assumes the bench resolves the open-drain SDA wire with a pull-up.
 */
`timescale 1ns/100ps
`include "ldc_defs.svh"

// ==========================================================
// Host model
module ldc_host_model (
   input  wire logic ref_clk,
   input  wire logic sda_w,
   output logic      scl,
   output logic      sda_pull
);
   // Idle bus: both lines released
   initial begin
      scl = 1'b1;
      sda_pull = 1'b0;
   end

   // Third of a bit, well above the slave's sync delay
   task automatic hb();
      repeat (10) @(posedge ref_clk);
   endtask

   // SDA only moves while SCL is low, except in start and stop
   task automatic start();
      sda_pull <= 1'b0;
      hb();
      scl <= 1'b1;
      hb();
      sda_pull <= 1'b1;
      hb();
      scl <= 1'b0;
      hb();
   endtask

   task automatic stop();
      sda_pull <= 1'b1;
      hb();
      scl <= 1'b1;
      hb();
      sda_pull <= 1'b0;
      hb();
   endtask

   // One bit, line sampled while SCL is high
   task automatic bit_io(input logic b, output logic r);
      sda_pull <= ~b;
      hb();
      scl <= 1'b1;
      hb();
      r = sda_w;
      scl <= 1'b0;
      hb();
   endtask

   // Byte MSB first, then the acknowledge slot
   task automatic xfer(input logic [7:0] d, output logic [7:0] q, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], r);
         q[i] = r;
      end
      bit_io(1'b1, r);
      ack = ~r;
   endtask

   task automatic wr_reg(input logic [6:0] dev, input logic [7:0] a, input logic [7:0] d, output logic ok);
      logic [7:0] q;
      logic       k1, k2, k3;
      start();
      xfer({dev, 1'b0}, q, k1);
      xfer(a, q, k2);
      xfer(d, q, k3);
      stop();
      ok = k1 & k2 & k3;
   endtask

   // Pointer write, repeated start, one byte read with a final no-ack
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
      logic [7:0] q;
      logic       k;
      start();
      xfer({`LDC_DEV_ADDR, 1'b0}, q, k);
      xfer(a, q, k);
      start();
      xfer({`LDC_DEV_ADDR, 1'b1}, q, k);
      xfer(8'hff, d, k);
      stop();
   endtask
endmodule // ldc_host_model

// ---- dv/tb.sv ----
/*
 * Self-checking bench for the LED configuration and scan-limit block.
 * Assumes ldc_host_model as bus master and shortened blink half periods.
 */
`timescale 1ns/100ps
`include "ldc_defs.svh"

module tb;
   localparam int SLOW = 4000;
   localparam int FAST = 2000;
   logic       ref_clk, rst, scl, sda_pull, sda_o, sda_oe, ok;
   logic       display_on, digit_clear, use_digit_intensity, blink_phase;
   logic [7:0] p0, p1, seg_out, rd;
   logic [2:0] scan_digit, held;
   int         fail_count, n_tests, cyc, clr_cnt, n;
   wire        sda_w = sda_pull ? 1'b0 : (sda_oe ? sda_o : 1'b1);

   // ==========================================================
   // Clock, clear pulse count, run limit
   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end

   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (digit_clear === 1'b1) clr_cnt <= clr_cnt + 1;
      if (cyc == 90000) begin
         fail_count++;
         wrap_up();
      end
   end

   ldc_top #(.SLOW_HALF_CYC(SLOW), .FAST_HALF_CYC(FAST)) dut_u (
      .ref_clk(ref_clk), .rst(rst), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe),
      .first_half_plane(p0), .second_half_plane(p1), .scan_digit(scan_digit), .seg_out(seg_out),
      .display_on(display_on), .digit_clear(digit_clear), .use_digit_intensity(use_digit_intensity),
      .blink_phase(blink_phase));
   ldc_host_model host_u (.ref_clk(ref_clk), .sda_w(sda_w), .scl(scl), .sda_pull(sda_pull));

   // ==========================================================
   // Tasks
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         fail_count++;
         $display("unexpected %s expected %0h seen %0h", nm, e, g);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      host_u.wr_reg(`LDC_DEV_ADDR, a, d, ok);
      chk("write ack", 1, ok);
   endtask

   task automatic rdc(input logic [7:0] a, input logic [7:0] e);
      host_u.rd_reg(a, rd);
      chk("read data", e, rd);
   endtask

   // Cycles until the blink phase changes, bounded
   task automatic edge_wait(output int c);
      logic ph;
      ph = blink_phase;
      c = 0;
      while (blink_phase === ph && c < 3 * SLOW) begin
         @(negedge ref_clk);
         c++;
      end
   endtask

   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   // ==========================================================
   // Main sequence
   initial begin
      rst = 1'b1;
      p0 = 8'h0a;
      p1 = 8'h0c;
      cyc = 0;
      clr_cnt = 0;
      fail_count = 0;
      n_tests = 0;
      repeat (8) @(posedge ref_clk);
      rst <= 1'b0;
      repeat (4) @(negedge ref_clk);
      chk("display_on", 0, display_on);
      chk("seg_out", 0, seg_out);
      rdc(`LDC_ADDR_CFG, 8'h80);
      rdc(`LDC_ADDR_SCAN, 8'h07);
      rdc(8'h20, 8'h00);
      wr(`LDC_ADDR_CFG, 8'h21);
      chk("clear pulses", 1, clr_cnt);
      chk("seg blink off", p0, seg_out);
      wr(`LDC_ADDR_CFG, 8'h43);
      chk("clear pulses", 1, clr_cnt);
      chk("intensity source", 1, use_digit_intensity);
      chk("seg spare bit", p0, seg_out);
      host_u.wr_reg(7'h61, `LDC_ADDR_CFG, 8'h00, ok);
      chk("foreign ack", 0, ok);
      chk("display_on", 1, display_on);
      wr(`LDC_ADDR_CFG, 8'h01);
      chk("intensity source", 0, use_digit_intensity);
      wr(`LDC_ADDR_SCAN, 8'hfa);
      repeat (400) @(negedge ref_clk);
      n = 0;
      repeat (2000) begin
         @(negedge ref_clk);
         if (scan_digit > n) n = scan_digit;
      end
      chk("scan max", 2, n);
      rdc(`LDC_ADDR_SCAN, 8'h02);
      wr(`LDC_ADDR_CFG, 8'h08);
      held = scan_digit;
      repeat (500) @(negedge ref_clk);
      chk("shutdown", 0, {display_on, seg_out, scan_digit ^ held});
      wr(`LDC_ADDR_CFG, 8'h09);
      for (int k = 0; k < 3; k++) begin
         edge_wait(n);
         if (k > 0) chk("slow half", SLOW, n + 3);
         repeat (3) @(negedge ref_clk);
         chk("seg blink", blink_phase ? 8'h0a : 8'h0c, seg_out);
      end
      if (blink_phase) edge_wait(n);
      rdc(`LDC_ADDR_CFG, 8'h09);
      wr(`LDC_ADDR_CFG, 8'h19);
      chk("phase after sync", 1, blink_phase);
      rdc(`LDC_ADDR_CFG, 8'h99);
      edge_wait(n);
      edge_wait(n);
      chk("half after sync", SLOW, n);
      wr(`LDC_ADDR_CFG, 8'h0d);
      edge_wait(n);
      edge_wait(n);
      chk("fast half", FAST, n);
      wrap_up();
   end
endmodule // tb
